// File: hw/dbom_top.sv
// Downstream buffer occupancy monitor with history, average and alerts
//
// Function
// [RULE1] Sample each channel every ms into 1000-deep history
// [RULE2] Channel sample is sum of its queue depths
// [RULE3] History readable anytime while sampling continues
// [RULE4] Samples are 8 bits, 0 empty, 255 full
// [RULE5] Byte depth divided by per-channel factor
// [RULE6] History kept for data, video, narrowband channels
// [RULE7] Core sends threshold and smoothing per channel
// [RULE8] Threshold arrival starts per-sample moving average
// [RULE9] Average above threshold gives one alert only
// [RULE10] Each threshold write re-arms one alert; a write in the cycle an alert fires leaves the channel disarmed
// [RULE11] Average uses alpha equal to 1/2^N
// [RULE12] Core lowers rate after alert, half percent
// [RULE13] Alerting on wideband, optional elsewhere
// [RULE14] Core caps aggregate rate per channel
// [RULE15] Core de-rating 90 to 99 percent
// [RULE16] Core bursts at most 1.5 ms
// [RULE17] Video output within 1.0 ms of rate
// [RULE18] Core rate limit includes inserted null packets
// [RULE19] Core burst default three frames per session
// [RULE20] Shift-based average step, zeroed on threshold
// [RULE21] History overwrites oldest, write pointer kept
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "dbom_consts.svh"

module dbom_top #(
    parameter int TICK_CYCLES = `DBOM_TICK_CYC
) (
    // Clock, reset, enable
    input  wire logic                                   aclk,
    input  wire logic                                   aresetn,
    input  wire logic                                   ce,
    // Queue depths in bytes, channel-major then queue
    input  wire logic [`DBOM_NCH*`DBOM_NQ*`DBOM_QDW-1:0] q_depth,
    // AXI4-Lite write address and data
    input  wire logic                                   s_axi_awvalid,
    output logic                                        s_axi_awready,
    input  wire logic [`DBOM_AW-1:0]                    s_axi_awaddr,
    input  wire logic                                   s_axi_wvalid,
    output logic                                        s_axi_wready,
    input  wire logic [31:0]                            s_axi_wdata,
    input  wire logic [3:0]                             s_axi_wstrb,
    // AXI4-Lite write response
    output logic                                        s_axi_bvalid,
    input  wire logic                                   s_axi_bready,
    output logic [1:0]                                  s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                                   s_axi_arvalid,
    output logic                                        s_axi_arready,
    input  wire logic [`DBOM_AW-1:0]                    s_axi_araddr,
    output logic                                        s_axi_rvalid,
    input  wire logic                                   s_axi_rready,
    output logic [31:0]                                 s_axi_rdata,
    output logic [1:0]                                  s_axi_rresp,
    // One-cycle alert per channel towards the control channel
    output logic [`DBOM_NCH-1:0]                        alert
);

    localparam int NCH = `DBOM_NCH;
    localparam int SW  = `DBOM_SW;
    localparam logic [NCH-1:0] CAP_MASK = `DBOM_ALERT_CAP;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic chreg_hit(input logic [`DBOM_AW-1:0] a);
        chreg_hit = (a[15:6] == `DBOM_CHR_PAGE);
    endfunction : chreg_hit

    function automatic logic hist_hit(input logic [`DBOM_AW-1:0] a);
        hist_hit = (a[15:14] == `DBOM_HIST_PAGE) &&
                   ({2'h0, a[11:2]} < `DBOM_HIST_LEN);
    endfunction : hist_hit

    // Flat history index of channel ch, slot idx
    function automatic logic [11:0] hidx(input logic [1:0] ch,
                                         input logic [9:0] idx);
        hidx = {10'h0, ch} * `DBOM_HIST_LEN + {2'h0, idx};
    endfunction : hidx

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        for (int b = 0; b < 4; b++) begin
            merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction : merge

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dbom_pkg::dbom_state_t   st_r;
    dbom_pkg::dbom_sample_t  hist_r [`DBOM_HIST_SIZE];
    logic [31:0]             tick_cnt_r;
    logic                    tick_r;
    logic                    run_r;
    logic [9:0]              wptr_r;
    logic                    wrapped_r;
    logic [1:0]              ch_idx_r;
    logic [4:0]              bit_r;
    logic [SW:0]             rem_r;
    logic [SW-1:0]           dvd_r;
    logic [SW-1:0]           quo_r;
    logic [SW-1:0]           norm_r    [NCH];
    logic [7:0]              thr_r     [NCH];
    logic [3:0]              shift_r   [NCH];
    logic [15:0]             avg_r     [NCH];
    logic                    armed_r   [NCH];
    logic                    active_r  [NCH];
    logic                    alerted_r [NCH];
    logic [NCH-1:0]          alert_r;
    logic [SW-1:0]           qsum      [NCH];
    logic [`DBOM_AW-1:0]     aw_addr_r;
    logic [31:0]             w_data_r;
    logic [3:0]              w_strb_r;
    logic                    aw_have_r;
    logic                    w_have_r;
    logic                    awready_r;
    logic                    wready_r;
    logic                    bvalid_r;
    logic [1:0]              bresp_r;
    logic                    arready_r;
    logic                    rvalid_r;
    logic [31:0]             rdata_r;
    logic [1:0]              rresp_r;

    // ------------------------------------------------------------------
    // Per-channel aggregate depth
    // ------------------------------------------------------------------
    // Queues of one channel are summed into one sample
    for (genvar c = 0; c < NCH; c++) begin : g_sum
        always_comb begin
            qsum[c] = '0;
            for (int q = 0; q < `DBOM_NQ; q++) begin
                qsum[c] = qsum[c] + {1'b0,
                    q_depth[(c*`DBOM_NQ+q)*`DBOM_QDW +: `DBOM_QDW]}; // RULE2
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer decode
    // ------------------------------------------------------------------
    // One restoring-division step per cycle keeps the divider small
    logic [SW:0]   trial_w;
    logic          ge_w;
    logic [SW:0]   rem_nxt;
    logic          last_ch_w;
    logic          start_w;
    logic          load_w;
    logic [1:0]    load_ch_w;
    logic [7:0]    sample_w;
    logic [11:0]   hw_idx_w;
    assign trial_w   = {rem_r[SW-1:0], dvd_r[SW-1]};
    assign ge_w      = trial_w >= {1'b0, norm_r[ch_idx_r]};          // RULE5
    assign rem_nxt   = ge_w ? trial_w - {1'b0, norm_r[ch_idx_r]} : trial_w;
    assign last_ch_w = (ch_idx_r == 2'(NCH-1));
    assign start_w   = (st_r == dbom_pkg::DBOM_IDLE) && tick_r && run_r;
    assign load_w    = start_w || ((st_r == dbom_pkg::DBOM_UPD) && !last_ch_w);
    assign load_ch_w = start_w ? 2'h0 : ch_idx_r + 2'h1;
    // Quotients beyond 255 clamp to full; a zero factor reads as full
    assign sample_w  = (|quo_r[SW-1:8]) ? 8'hff : quo_r[7:0];        // RULE4
    assign hw_idx_w  = hidx(ch_idx_r, wptr_r);

    // ------------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_r <= 32'h0;
            tick_r     <= 1'b0;
        end else if (ce) begin
            tick_r     <= (tick_cnt_r == 32'(TICK_CYCLES - 1));     // RULE1
            tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ?
                          32'h0 : tick_cnt_r + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // Sampling sequencer: all channels in turn, then the pointer moves
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r      <= dbom_pkg::DBOM_IDLE;
            ch_idx_r  <= 2'h0;
            bit_r     <= 5'h0;
            rem_r     <= '0;
            dvd_r     <= '0;
            quo_r     <= '0;
            wptr_r    <= 10'h0;
            wrapped_r <= 1'b0;
        end else if (ce) begin
            unique case (st_r)
                dbom_pkg::DBOM_IDLE: begin
                    if (start_w) begin
                        st_r <= dbom_pkg::DBOM_DIV;
                    end
                end
                dbom_pkg::DBOM_DIV: begin
                    rem_r <= rem_nxt;
                    dvd_r <= {dvd_r[SW-2:0], 1'b0};
                    quo_r <= {quo_r[SW-2:0], ge_w};
                    bit_r <= bit_r - 5'h1;
                    if (bit_r == 5'h0) begin
                        st_r <= dbom_pkg::DBOM_UPD;
                    end
                end
                dbom_pkg::DBOM_UPD: begin
                    if (last_ch_w) begin
                        st_r <= dbom_pkg::DBOM_IDLE;
                        // Oldest slot is overwritten after the wrap
                        if ({2'h0, wptr_r} == `DBOM_HIST_LEN - 12'd1) begin
                            wptr_r    <= 10'h0;                     // RULE21
                            wrapped_r <= 1'b1;
                        end else begin
                            wptr_r <= wptr_r + 10'h1;               // RULE21
                        end
                    end else begin
                        st_r <= dbom_pkg::DBOM_DIV;
                    end
                end
            endcase
            if (load_w) begin
                ch_idx_r <= load_ch_w;
                dvd_r    <= qsum[load_ch_w];
                rem_r    <= '0;
                quo_r    <= '0;
                bit_r    <= 5'(SW - 1);
            end
        end
    end

    // ------------------------------------------------------------------
    // History storage; one write port, reads never block it
    // ------------------------------------------------------------------
    // Every channel type shares the same store and sequencer
    always_ff @(posedge aclk) begin
        if (ce && (st_r == dbom_pkg::DBOM_UPD)) begin
            hist_r[hw_idx_w] <= sample_w;                           // RULE1 RULE6
        end
    end

    // ------------------------------------------------------------------
    // Bus write decode
    // ------------------------------------------------------------------
    logic          wr_do_w;
    logic          wr_ch_w;
    logic [1:0]    wr_sel_w;
    logic [1:0]    wr_off_w;
    logic          wr_ok_w;
    logic [31:0]   wr_ctrl_w;
    assign wr_do_w   = aw_have_r && w_have_r && !bvalid_r;
    assign wr_ch_w   = wr_do_w && chreg_hit(aw_addr_r);
    assign wr_sel_w  = aw_addr_r[5:4];
    assign wr_off_w  = aw_addr_r[3:2];
    assign wr_ok_w   = chreg_hit(aw_addr_r) || hist_hit(aw_addr_r) ||
                       (aw_addr_r == `DBOM_OFF_CTRL) ||
                       (aw_addr_r == `DBOM_OFF_WPTR);
    assign wr_ctrl_w = merge({31'h0, run_r}, w_data_r, w_strb_r);

    // ------------------------------------------------------------------
    // Per-channel settings, average and alert
    // ------------------------------------------------------------------
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic               upd_c;
        logic               thr_wr_c;
        logic               fire_c;
        logic signed [16:0] diff_c;
        logic signed [16:0] step_c;
        logic [15:0]        avg_nxt_c;
        logic [31:0]        thr_new_c;
        logic [31:0]        norm_new_c;
        logic [31:0]        shift_new_c;
        assign upd_c    = (st_r == dbom_pkg::DBOM_UPD) && (ch_idx_r == 2'(c));
        assign thr_wr_c = wr_ch_w && (wr_sel_w == 2'(c)) &&
                          (wr_off_w == `DBOM_CHR_THR);
        // Fixed point 8.8; alpha = 2^-N becomes an arithmetic shift
        assign diff_c    = $signed({1'b0, sample_w, 8'h00}) -
                           $signed({1'b0, avg_r[c]});               // RULE20
        assign step_c    = diff_c >>> shift_r[c];                   // RULE11
        assign avg_nxt_c = avg_r[c] + step_c[15:0];                 // RULE11
        assign fire_c    = upd_c && active_r[c] && armed_r[c] &&
                           CAP_MASK[c] &&
                           (avg_nxt_c > {thr_r[c], 8'h00});         // RULE9 RULE13
        assign thr_new_c   = merge({24'h0, thr_r[c]}, w_data_r, w_strb_r);
        assign norm_new_c  = merge({11'h0, norm_r[c]}, w_data_r, w_strb_r);
        assign shift_new_c = merge({28'h0, shift_r[c]}, w_data_r, w_strb_r);

        // Settings written by the core
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                norm_r[c]  <= `DBOM_NORM_RST;
                thr_r[c]   <= `DBOM_THR_RST;
                shift_r[c] <= `DBOM_SHIFT_RST;
            end else if (ce && wr_ch_w && (wr_sel_w == 2'(c))) begin
                if (wr_off_w == `DBOM_CHR_NORM) begin
                    norm_r[c] <= norm_new_c[SW-1:0];                // RULE5
                end
                if (wr_off_w == `DBOM_CHR_THR) begin
                    thr_r[c] <= thr_new_c[7:0];
                end
                if (wr_off_w == `DBOM_CHR_SHIFT) begin
                    shift_r[c] <= shift_new_c[3:0];
                end
            end
        end

        // Average and one-shot alert; an alert beats a same-cycle re-arm
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                avg_r[c]     <= 16'h0;
                armed_r[c]   <= 1'b0;
                active_r[c]  <= 1'b0;
                alerted_r[c] <= 1'b0;
                alert_r[c]   <= 1'b0;
            end else if (ce) begin
                alert_r[c] <= fire_c;                               // RULE9
                if (fire_c) begin
                    armed_r[c]   <= 1'b0;                           // RULE9
                    alerted_r[c] <= 1'b1;
                end else if (thr_wr_c) begin
                    armed_r[c]   <= 1'b1;                           // RULE10
                    alerted_r[c] <= 1'b0;
                end
                if (thr_wr_c) begin
                    active_r[c] <= 1'b1;                            // RULE8
                    avg_r[c]    <= 16'h0;                           // RULE20
                end else if (upd_c && active_r[c]) begin
                    avg_r[c] <= avg_nxt_c;                          // RULE8
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register and write channel handshakes
    // ------------------------------------------------------------------
    // Address and data are taken in either order; response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_r     <= `DBOM_RUN_RST;
            aw_addr_r <= '0;
            w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= `DBOM_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && awready_r) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (wr_do_w) begin
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_ok_w ? `DBOM_RESP_OKAY : `DBOM_RESP_SLV;
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                if (aw_addr_r == `DBOM_OFF_CTRL) begin
                    run_r <= wr_ctrl_w[`DBOM_CTRL_RUN];
                end
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read decode; history reads use their own index, so no stall
    // ------------------------------------------------------------------
    logic [1:0]    rd_sel_w;
    logic [31:0]   rd_chr_w;
    logic [31:0]   rd_data_w;
    logic          rd_ok_w;
    assign rd_sel_w = s_axi_araddr[5:4];
    assign rd_chr_w =
        (s_axi_araddr[3:2] == `DBOM_CHR_NORM)  ? {11'h0, norm_r[rd_sel_w]} :
        (s_axi_araddr[3:2] == `DBOM_CHR_THR)   ? {24'h0, thr_r[rd_sel_w]} :
        (s_axi_araddr[3:2] == `DBOM_CHR_SHIFT) ? {28'h0, shift_r[rd_sel_w]} :
        {12'h0, CAP_MASK[rd_sel_w], active_r[rd_sel_w],
         armed_r[rd_sel_w], alerted_r[rd_sel_w], avg_r[rd_sel_w]};
    assign rd_data_w =
        (s_axi_araddr == `DBOM_OFF_CTRL) ? {31'h0, run_r} :
        (s_axi_araddr == `DBOM_OFF_WPTR) ?
            {15'h0, wrapped_r, 6'h0, wptr_r} :                      // RULE21
        chreg_hit(s_axi_araddr) ? rd_chr_w :
        hist_hit(s_axi_araddr) ?
            {24'h0, hist_r[hidx(s_axi_araddr[13:12],
                               s_axi_araddr[11:2])]} :              // RULE3
        32'h0;
    assign rd_ok_w = chreg_hit(s_axi_araddr) || hist_hit(s_axi_araddr) ||
                     (s_axi_araddr == `DBOM_OFF_CTRL) ||
                     (s_axi_araddr == `DBOM_OFF_WPTR);

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0;
            rresp_r   <= `DBOM_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_data_w;
                rresp_r   <= rd_ok_w ? `DBOM_RESP_OKAY : `DBOM_RESP_SLV;
            end
            if (rvalid_r && s_axi_rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign alert         = alert_r;

endmodule : dbom_top

// File: hw/dbom_consts.svh
// Constants of the downstream buffer occupancy monitor: map, resets, timing
`ifndef DBOM_CONSTS_SVH
`define DBOM_CONSTS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define DBOM_NCH        4
`define DBOM_NQ         2
`define DBOM_QDW        20
`define DBOM_SW         21
`define DBOM_AW         16
`define DBOM_HIST_LEN   12'd1000
`define DBOM_HIST_SIZE  4000

// ----------------------------------------------------------------------
// Register offsets: byte addresses, page codes, word indices
// ----------------------------------------------------------------------
`define DBOM_OFF_CTRL   16'h0000
`define DBOM_OFF_WPTR   16'h0004
`define DBOM_CHR_PAGE   10'h004
`define DBOM_CHR_NORM   2'h0
`define DBOM_CHR_THR    2'h1
`define DBOM_CHR_SHIFT  2'h2
`define DBOM_CHR_STAT   2'h3
`define DBOM_HIST_PAGE  2'h1

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define DBOM_CTRL_RUN   0
`define DBOM_WPTR_WRAP  16
`define DBOM_RUN_RST    1'b1
`define DBOM_NORM_RST   21'h000097
`define DBOM_THR_RST    8'hff
`define DBOM_SHIFT_RST  4'h3
`define DBOM_ALERT_CAP  4'b1011

// ----------------------------------------------------------------------
// Bus answers and timing
// ----------------------------------------------------------------------
`define DBOM_RESP_OKAY  2'b00
`define DBOM_RESP_SLV   2'b10
`define DBOM_MS_NS      1000000
`define DBOM_CLK_NS     10
`define DBOM_TICK_CYC   (`DBOM_MS_NS / `DBOM_CLK_NS)

`endif

// File: hw/dbom_pkg.sv
// Types shared by the downstream buffer occupancy monitor
package dbom_pkg;
    // Sampling sequencer; idle -> divide -> update along a Gray path
    typedef enum logic [1:0] {
        DBOM_IDLE = 2'b00,
        DBOM_DIV  = 2'b01,
        DBOM_UPD  = 2'b11
    } dbom_state_t;

    typedef logic [7:0] dbom_sample_t;
endpackage : dbom_pkg

// File: test/dbom_queue_model.sv
// Output queue model feeding byte depths to the occupancy monitor
`timescale 1ns/10ps
module dbom_queue_model (
    // Per-queue byte depths set by the bench
    input  wire logic [19:0]  dep [8],
    // Packed depths, channel-major then queue
    output logic      [159:0] q_depth
);
    // Two queues per channel; the monitor must add them, not pick one
    always_comb begin
        for (int k = 0; k < 8; k++) q_depth[k*20 +: 20] = dep[k];
    end
endmodule : dbom_queue_model

// File: test/dbom_chk_sva.sv
// Bus and alert checks for the occupancy monitor
`timescale 1ns/10ps
module dbom_chk (
    // Clock, reset, enable
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    // Bus handshakes
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Alerts
    input wire logic [3:0]  alert
);
    // One domain, so clock and reset are given once
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read not answered");
    a_read_hold: assert property (ce && s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken");
    a_read_err: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
        |-> s_axi_rdata == 32'h0) else $error("error read has data");
    a_write_hold: assert property (ce && s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_write_block: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
    a_alert_pulse: assert property ((alert & $past(alert)) == 4'h0)
        else $error("alert longer than one cycle");
    a_video_quiet: assert property (alert[2] == 1'h0)
        else $error("alert on video channel");
endmodule : dbom_chk
bind dbom_top dbom_chk u_dbom_chk (.*);

// File: test/testbench.sv
// Register-level bench for the occupancy monitor
`timescale 1ns/10ps
`include "dbom_consts.svh"
module testbench;
    logic         aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
    logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic         s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic         s_axi_rready = 1'h0;
    logic [15:0]  s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0, p;
    logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
    logic [3:0]   s_axi_wstrb = 4'hf, alert;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic         s_axi_arready, s_axi_rvalid;
    logic [159:0] q_depth;
    logic [19:0]  dep [8] = '{default: 20'h0};
    int           n_errors = 0, n_tests = 0, n_alert = 0;
    // Short tick keeps the run small; counts scale with it
    dbom_top #(.TICK_CYCLES(200)) u_dbom_top (.*);
    dbom_queue_model u_dbom_queue_model (.*);
    always #5 aclk = ~aclk;
    // Alerts on channel 0 are counted as they pulse
    always @(posedge aclk) if (alert[0] === 1'h1) n_alert <= n_alert + 1;
    task automatic report_and_stop(bit t);
        n_errors += t;
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Both halves offered together, each released once taken
    task automatic wr(logic [15:0] a, logic [31:0] d);
        int i;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        for (i = 0; i < 50 && !(s_axi_bvalid === 1'h1 && s_axi_bready);
             i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'h1;
        end
        if (i == 50) report_and_stop(1'h1);
        s_axi_bready <= 1'h0;
        chk("bresp", `DBOM_RESP_OKAY, s_axi_bresp);
        @(posedge aclk);
    endtask : wr
    task automatic rd(logic [15:0] a, logic [1:0] er, logic [31:0] ed,
                      string nm);
        int i;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        for (i = 0; i < 50 && !(s_axi_rvalid === 1'h1 && s_axi_rready);
             i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
        end
        if (i == 50) report_and_stop(1'h1);
        rd_d = s_axi_rdata;
        s_axi_rready <= 1'h0;
        chk("rresp", er, s_axi_rresp);
        if (nm != "") chk(nm, ed, rd_d);
        @(posedge aclk);
    endtask : rd
    // Main sequence: reset values, sampling, alert and re-arm
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(16'h0000, `DBOM_RESP_OKAY, 32'h1, "ctrl");
        rd(16'h0100, `DBOM_RESP_OKAY, 32'h97, "norm");
        rd(16'h010c, `DBOM_RESP_OKAY, 32'h80000, "stat0");
        rd(16'h012c, `DBOM_RESP_OKAY, 32'h0, "stat2");
        rd(16'h0008, `DBOM_RESP_SLV, 32'h0, "gap");
        rd(16'h4fa0, `DBOM_RESP_SLV, 32'h0, "hist_end");
        dep[0] <= 20'h64;
        dep[1] <= 20'h3c;
        dep[2] <= 20'hfffff;
        dep[3] <= 20'hfffff;
        wr(16'h0100, 32'h4);
        wr(16'h0108, 32'h0);
        wr(16'h0104, 32'h27);
        for (int k = 0; k < 1000 && n_alert < 1; k++) @(posedge aclk);
        repeat (600) @(posedge aclk);
        chk("alerts", 32'h1, n_alert);
        rd(16'h010c, `DBOM_RESP_OKAY, 32'hd2800, "stat0");
        rd(16'h0004, `DBOM_RESP_OKAY, 32'h0, "");
        chk("wrap", 32'h0, {31'h0, rd_d[16]});
        p = 16'(rd_d[9:0] - 10'h1) << 2;
        rd(16'h4000 + p, `DBOM_RESP_OKAY, 32'h28, "hist0");
        rd(16'h5000 + p, `DBOM_RESP_OKAY, 32'hff, "hist1");
        rd(16'h6000 + p, `DBOM_RESP_OKAY, 32'h0, "hist2");
        dep[0] <= 20'h60;
        wr(16'h0104, 32'h26);
        for (int k = 0; k < 1000 && n_alert < 2; k++) @(posedge aclk);
        chk("rearm", 32'h2, n_alert);
        report_and_stop(1'h0);
    end
endmodule : testbench
